// ---- logic/spwe_pkg.sv ----
// shared constants and carrier types for the soft power wake enable block
package spwe_pkg;

   // *****************************
   // bus geometry
   // *****************************
   localparam int AW = 10;
   localparam int DW = 32;
   localparam int RW = 8;

   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_EN1 = 8'hB0;
   localparam logic [7:0] IDX_EN2 = 8'hB1;
   localparam logic [7:0] IDX_STAT1 = 8'hB2;
   localparam logic [7:0] IDX_STAT2 = 8'hB3;
   localparam logic [7:0] IDX_IST = 8'hB4;
   localparam logic [7:0] IDX_ICLR = 8'hB5;
   localparam logic [7:0] IDX_IEN = 8'hB6;

   // *****************************
   // reset values and field masks
   // *****************************
   localparam logic [7:0] RST_EN1 = 8'h00;
   localparam logic [7:0] RST_EN2 = 8'h80;
   localparam logic [7:0] RST_STAT = 8'h00;
   localparam logic [7:0] EN2_MASK = 8'hAB;
   localparam logic [7:0] LATCH1_MASK = 8'hCF;
   localparam logic [7:0] GROUP1_MASK = 8'h30;
   localparam logic [7:0] WAKE2_MASK = 8'h2B;

   // first enable and status register bit positions
   localparam int B_RI_A = 0;
   localparam int B_RI_B = 1;
   localparam int B_KCLK = 2;
   localparam int B_MCLK = 3;
   localparam int B_GRP_A = 4;
   localparam int B_GRP_B = 5;
   localparam int B_IRRX = 6;
   localparam int B_ALARM = 7;
   // second enable and status register bit positions
   localparam int B_RXD_A = 0;
   localparam int B_RXD_B = 1;
   localparam int B_RING = 3;
   localparam int B_CIR = 5;
   localparam int B_OFF_EN = 7;

   // *****************************
   // pins and interrupt causes
   // *****************************
   localparam int NPIN = 9;
   localparam logic [NPIN-1:0] PIN_IDLE = 9'h1FF;
   localparam int P_RI_A = 0;
   localparam int P_RI_B = 1;
   localparam int P_KCLK = 2;
   localparam int P_MCLK = 3;
   localparam int P_IRRX = 4;
   localparam int P_RXD_A = 5;
   localparam int P_RXD_B = 6;
   localparam int P_RING = 7;
   localparam int P_BUTTON = 8;

   localparam int IRQ_W = 2;
   localparam int I_WAKE = 0;
   localparam int I_OFF = 1;

   // external pins, all idle high
   typedef struct packed {
      logic button_n;
      logic ring_input_n;
      logic serial_rx_b;
      logic serial_rx_a;
      logic infrared_rx_b;
      logic mouse_clk;
      logic kbd_clk;
      logic ring_ind_b_n;
      logic ring_ind_a_n;
   } spwe_pins_t;

   // on-chip sources, same clock domain
   typedef struct packed {
      logic consumer_ir;
      logic clock_alarm;
      logic group_irq_b;
      logic group_irq_a;
   } spwe_int_t;

endpackage

// ---- logic/spwe_pin_sync.sv ----
// two-stage pin synchroniser with falling edge detect per pin
`timescale 1ns/100ps
module spwe_pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] IDLE = '1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] fall_o
);

   // *****************************
   // per pin chain
   // *****************************
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : g_pin
         logic s1;
         logic s2;
         logic s3;
         // reset to idle level so release gives no false edge
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               s1 <= IDLE[g];
               s2 <= IDLE[g];
               s3 <= IDLE[g];
            end else begin
               s1 <= pin_i[g];
               s2 <= s1;
               s3 <= s2;
            end
         end
         // s1 feeds only s2, edge taken from later stages
         assign fall_o[g] = s3 & ~s2;
      end
   endgenerate

endmodule

// ---- logic/spwe_irq.sv ----
// sticky interrupt status with write-one-clear and enable mask
`timescale 1ns/100ps
module spwe_irq #(
   parameter int W = 2
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] event_i,
   input wire logic clr_we_i,
   input wire logic en_we_i,
   input wire logic [W-1:0] wdata_i,
   output logic [W-1:0] status_o,
   output logic [W-1:0] enable_o,
   output logic irq_o
);

   // sticky status, a new event beats a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_o <= '0;
      end else begin
         status_o <= (status_o & ~(clr_we_i ? wdata_i : '0)) | event_i;
      end
   end

   // enable mask
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enable_o <= '0;
      end else if (en_we_i) begin
         enable_o <= wdata_i;
      end
   end

   // level interrupt, registered so the pin is glitch free
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(status_o & enable_o);
      end
   end

endmodule

// ---- logic/spwe_top.sv ----
// soft power wake enable block with wishbone register slave
//
// Function
// RULE1 - enabled event may wake, disabled event ignored
// RULE2 - first enable bits 0-6 map sources
// RULE3 - first enable bit 7 gates alarm
// RULE4 - second enable bits 0,1 gate receive data
// RULE5 - second enable bit 3 gates ring pin
// RULE6 - second enable bit 5 gates consumer IR
// RULE7 - second enable bit 7 permits button off
// RULE8 - reset values 0x00 and 0x80
// RULE9 - pin falls latched, cleared by status read
// RULE10 - group interrupt status follows source live
// RULE11 - status shows which enabled source woke
// RULE12 - request is OR of enabled events, low
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/100ps
module spwe_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [spwe_pkg::AW-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [spwe_pkg::DW-1:0] wb_dat_i,
   output logic [spwe_pkg::DW-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire spwe_pkg::spwe_pins_t pins_i,
   input wire spwe_pkg::spwe_int_t int_i,
   output logic power_up_request_n_o,
   output logic power_off_o,
   output logic irq_o
);
   import spwe_pkg::*;

   // *****************************
   // declarations
   // *****************************
   logic [NPIN-1:0] pin_fall;
   logic hit;
   logic wr;
   logic rd;
   logic [7:0] idx;
   logic rd_st1;
   logic rd_st2;
   logic [RW-1:0] en1;
   logic [RW-1:0] en2;
   logic [RW-1:0] ev1;
   logic [RW-1:0] ev2;
   logic [RW-1:0] st1_lat;
   logic [RW-1:0] grp_q;
   logic [RW-1:0] st1_view;
   logic [RW-1:0] st2;
   logic [RW-1:0] next_rdata;
   logic next_req;
   logic req_q;
   logic [IRQ_W-1:0] irq_ev;
   logic [IRQ_W-1:0] irq_st;
   logic [IRQ_W-1:0] irq_en;

   // *****************************
   // pin synchroniser
   // *****************************
   spwe_pin_sync #(
      .W(NPIN),
      .IDLE(PIN_IDLE)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(pins_i),
      .fall_o(pin_fall)
   );

   // *****************************
   // wishbone slave decode
   // *****************************
   // one wait state, ack held low in the cycle after it to drop
   assign hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign idx = wb_adr_i[AW-1:2];
   assign wr = hit & wb_we_i & wb_sel_i[0];
   assign rd = hit & ~wb_we_i;
   assign rd_st1 = rd & (idx == IDX_STAT1);
   assign rd_st2 = rd & (idx == IDX_STAT2);

   // acknowledge, unmapped indices also answer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= hit;
      end
   end

   // read mux, write-only and unmapped read as zero
   always_comb begin
      next_rdata = '0;
      if (idx == IDX_EN1) begin
         next_rdata = en1;
      end else if (idx == IDX_EN2) begin
         next_rdata = en2;
      end else if (idx == IDX_STAT1) begin
         next_rdata = st1_view;
      end else if (idx == IDX_STAT2) begin
         next_rdata = st2;
      end else if (idx == IDX_IST) begin
         next_rdata = RW'(irq_st);
      end else if (idx == IDX_IEN) begin
         next_rdata = RW'(irq_en);
      end
   end

   // read data register, narrow data in low bits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= '0;
      end else if (rd) begin
         wb_dat_o <= DW'(next_rdata);
      end else begin
         wb_dat_o <= '0;
      end
   end

   // *****************************
   // wake enable registers
   // *****************************
   // reserved bits of the second register are never stored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en1 <= RST_EN1; // RULE8
         en2 <= RST_EN2; // RULE8
      end else if (wr && idx == IDX_EN1) begin
         en1 <= wb_dat_i[RW-1:0];
      end else if (wr && idx == IDX_EN2) begin
         en2 <= wb_dat_i[RW-1:0] & EN2_MASK;
      end
   end

   // *****************************
   // wake events
   // *****************************
   // first register source order
   assign ev1 = {int_i.clock_alarm, // RULE3
                 pin_fall[P_IRRX],
                 int_i.group_irq_b,
                 int_i.group_irq_a,
                 pin_fall[P_MCLK],
                 pin_fall[P_KCLK],
                 pin_fall[P_RI_B],
                 pin_fall[P_RI_A]}; // RULE2

   // second register sources, reserved slots tied low
   assign ev2 = {1'b0,
                 1'b0,
                 int_i.consumer_ir, // RULE6
                 1'b0,
                 pin_fall[P_RING], // RULE5
                 1'b0,
                 pin_fall[P_RXD_B],
                 pin_fall[P_RXD_A]}; // RULE4

   // *****************************
   // wake status
   // *****************************
   // only enabled sources latch, set beats clear-on-read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st1_lat <= RST_STAT;
      end else begin
         st1_lat <= (st1_lat & ~{RW{rd_st1}}) // RULE9
                    | (ev1 & en1 & LATCH1_MASK); // RULE11
      end
   end

   // group interrupts are not held, they track the source
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         grp_q <= RST_STAT;
      end else begin
         grp_q <= ev1 & en1 & GROUP1_MASK; // RULE10
      end
   end

   assign st1_view = st1_lat | grp_q;

   // receive data, ring and consumer IR causes, read to clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st2 <= RST_STAT;
      end else begin
         st2 <= (st2 & ~{RW{rd_st2}})
                | (ev2 & en2 & WAKE2_MASK); // RULE1
      end
   end

   // *****************************
   // power request and power off
   // *****************************
   // disabling a source also withdraws its pending request
   assign next_req = |(st1_view & en1)
                     | |(st2 & en2 & WAKE2_MASK); // RULE12

   // active low request pin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         power_up_request_n_o <= 1'b1;
         req_q <= 1'b0;
      end else begin
         power_up_request_n_o <= ~next_req; // RULE12
         req_q <= next_req;
      end
   end

   // one pulse per button press while power off is permitted
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         power_off_o <= 1'b0;
      end else begin
         power_off_o <= pin_fall[P_BUTTON] & en2[B_OFF_EN]; // RULE7
      end
   end

   // *****************************
   // interrupt
   // *****************************
   assign irq_ev[I_WAKE] = next_req & ~req_q;
   assign irq_ev[I_OFF] = pin_fall[P_BUTTON] & en2[B_OFF_EN];

   spwe_irq #(
      .W(IRQ_W)
   ) u_irq (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .event_i(irq_ev),
      .clr_we_i(wr && idx == IDX_ICLR),
      .en_we_i(wr && idx == IDX_IEN),
      .wdata_i(wb_dat_i[IRQ_W-1:0]),
      .status_o(irq_st),
      .enable_o(irq_en),
      .irq_o(irq_o)
   );

   // *****************************
   // assertions
   // *****************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // request pin goes low two edges after an enabled event, one edge after it latches
   sequence s_req_after_latch;
      ##2 !power_up_request_n_o;
   endsequence

   // keyboard clock drop reaches the status within four edges
   sequence s_kclk_drop;
      $fell(pins_i.kbd_clk) && en1[B_KCLK] && !rd_st1;
   endsequence

   property p_en_reset;
      @(posedge clk_i) disable iff (1'b0)
      rst_i |=> (en1 == RST_EN1 && en2 == RST_EN2);
   endproperty
   a_en_reset: assert property (p_en_reset) // RULE8
      else $error("enable registers wrong after reset");

   property p_disabled_quiet;
      !en1[B_MCLK] && !st1_lat[B_MCLK] |=> !st1_lat[B_MCLK];
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) // RULE1
      else $error("disabled mouse clock latched a wake");

   property p_map_mclk;
      pin_fall[P_MCLK] && en1[B_MCLK] |=> st1_lat[B_MCLK];
   endproperty
   a_map_mclk: assert property (p_map_mclk) // RULE2
      else $error("mouse clock fall not in its status bit");

   property p_alarm_wake;
      int_i.clock_alarm && en1[B_ALARM] |-> s_req_after_latch;
   endproperty
   a_alarm_wake: assert property (p_alarm_wake) // RULE3
      else $error("enabled alarm did not request power");

   property p_rxd_wake;
      pin_fall[P_RXD_A] && en2[B_RXD_A] |=> st2[B_RXD_A];
   endproperty
   a_rxd_wake: assert property (p_rxd_wake) // RULE4
      else $error("receive data fall not latched");

   property p_ring_wake;
      pin_fall[P_RING] && en2[B_RING] |-> s_req_after_latch;
   endproperty
   a_ring_wake: assert property (p_ring_wake) // RULE5
      else $error("enabled ring did not request power");

   property p_cir_quiet;
      !en2[B_CIR] && !st2[B_CIR] |=> !st2[B_CIR];
   endproperty
   a_cir_quiet: assert property (p_cir_quiet) // RULE6
      else $error("disabled consumer IR latched a wake");

   property p_button_off;
      pin_fall[P_BUTTON] |=> power_off_o == $past(en2[B_OFF_EN]);
   endproperty
   a_button_off: assert property (p_button_off) // RULE7
      else $error("button power off does not follow its enable");

   property p_kclk_latch;
      s_kclk_drop |-> ##[1:4] st1_lat[B_KCLK];
   endproperty
   a_kclk_latch: assert property (p_kclk_latch) // RULE9
      else $error("keyboard clock drop not latched");

   property p_read_clear;
      rd_st1 && !(|(ev1 & en1 & LATCH1_MASK)) |=> st1_lat == RST_STAT;
   endproperty
   a_read_clear: assert property (p_read_clear) // RULE9
      else $error("status read did not clear latched bits");

   property p_group_live;
      ##1 st1_view[B_GRP_A] == $past(int_i.group_irq_a && en1[B_GRP_A]);
   endproperty
   a_group_live: assert property (p_group_live) // RULE10
      else $error("group status does not track its source");

   property p_cause_enabled;
      $rose(st1_lat[B_RI_A]) |-> $past(en1[B_RI_A]);
   endproperty
   a_cause_enabled: assert property (p_cause_enabled) // RULE11
      else $error("status set by a disabled source");

   property p_idle_high;
      !next_req |=> power_up_request_n_o;
   endproperty
   a_idle_high: assert property (p_idle_high) // RULE12
      else $error("request low with no enabled event");

endmodule

// ---- dv/spwe_supply_model.sv ----
// behavioural model of the system supply switch beyond the block
`timescale 1ns/100ps
module spwe_supply_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic power_up_request_n_i,
   input wire logic power_off_i,
   output logic sys_on_o
);
   logic req_q;

   // ***************************
   // supply state
   // ***************************
   // switch on at a falling request, off at an off pulse;
   // edge based, so a request that stays low cannot fight the button
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_q <= 1'b1;
         sys_on_o <= 1'b0;
      end else begin
         req_q <= power_up_request_n_i;
         if (power_off_i === 1'b1) begin
            sys_on_o <= 1'b0;
         end else if (req_q && !power_up_request_n_i) begin
            sys_on_o <= 1'b1;
         end
      end
   end
endmodule

// ---- dv/test_soft_power_wake_enable.sv ----
// self-checking testbench for the soft power wake enable block
`timescale 1ns/100ps
module test_soft_power_wake_enable;
   import spwe_pkg::*;
   logic clk_i, rst_i, cyc, stb, we_r, wb_ack_o, req_n, off, irq, sys_on;
   logic [AW-1:0] adr;
   logic [3:0] sel;
   logic [DW-1:0] dat, wb_dat_o;
   logic [NPIN-1:0] pins;
   logic [3:0] ints;
   logic [7:0] expq[$];
   logic [7:0] r, e, m;
   int num_errors, checked, offs, seed;
   int bp[8] = '{B_RI_A, B_RI_B, B_KCLK, B_MCLK, B_IRRX, B_RXD_A,
      B_RXD_B, B_RING};
   int ib[4] = '{B_GRP_A, B_GRP_B, B_ALARM, B_CIR};

   spwe_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we_r), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .pins_i(pins), .int_i(ints), .power_up_request_n_o(req_n),
      .power_off_o(off), .irq_o(irq));

   spwe_supply_model supply (.clk_i(clk_i), .rst_i(rst_i),
      .power_up_request_n_i(req_n), .power_off_i(off), .sys_on_o(sys_on));

   // ***************************
   // clock, watchdog, monitors
   // ***************************
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   // cuts a hang short
   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      report_and_stop;
   end

   // off pulses are one cycle, so count them at every edge
   always @(posedge clk_i) begin
      if (off === 1'b1) offs++;
   end

   // read data stands one cycle with ack: take it at the edge that
   // samples ack high, and compare the oldest note
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && we_r === 1'b0 && expq.size() > 0) begin
         chk(wb_dat_o, {24'h0, expq.pop_front()});
      end
   end

   // ***************************
   // tasks
   // ***************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen,
            exp);
      end
   endtask

   task automatic report_and_stop;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // classic cycle: hold until ack is sampled high at a rising edge,
   // then release at that same edge
   task automatic wb(input logic w, input logic [7:0] idx,
      input logic [7:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we_r <= w;
      adr <= {idx, 2'b00};
      dat <= {24'h0, d};
      n = 0;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) begin
         n++;
         if (n > 40) begin
            num_errors++;
            report_and_stop;
         end
         @(posedge clk_i);
      end
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      wb(1'b1, idx, d);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] x);
      expq.push_back(x);
      wb(1'b0, idx, 8'h00);
   endtask

   // wait edges, then look at settled outputs
   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask

   // a three-cycle low pulse on one pin
   task automatic drop(input int p);
      @(posedge clk_i);
      pins[p] <= 1'b0;
      repeat (3) @(posedge clk_i);
      pins[p] <= 1'b1;
      settle(2);
   endtask

   // ***************************
   // main sequence
   // ***************************
   initial begin
      seed = 66;
      cyc = 1'b0;
      stb = 1'b0;
      we_r = 1'b0;
      adr = '0;
      sel = 4'hF;
      dat = '0;
      pins = PIN_IDLE;
      ints = 4'h0;
      rst_i = 1'b1;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(IDX_EN1, RST_EN1);
      rd(IDX_EN2, RST_EN2);
      rd(8'h20, 8'h00);
      r = 8'($random(seed));
      wr(IDX_EN1, r);
      rd(IDX_EN1, r);
      wr(IDX_EN2, r);
      rd(IDX_EN2, r & EN2_MASK);
      wr(IDX_EN1, 8'h00);
      wr(IDX_EN2, 8'h00);
      wr(IDX_IEN, 8'h01);
      // each pin source blocked, then enabled alone
      for (int i = 0; i < 8; i++) begin
         e = 8'(IDX_EN1 + (i > 4));
         m = 8'(1 << bp[i]);
         drop(i);
         chk(req_n, 1'b1);
         wr(e, m);
         drop(i);
         chk(req_n, 1'b0);
         chk(sys_on, 1'b1);
         rd(8'(e + 2), m);
         settle(2);
         chk(req_n, 1'b1);
         chk(irq, 1'b1);
         wr(IDX_ICLR, 8'h01);
         settle(1);
         chk(irq, 1'b0);
         wr(e, 8'h00);
      end
      // internal sources with the interrupt masked
      wr(IDX_IEN, 8'h00);
      for (int j = 0; j < 4; j++) begin
         e = (j == 3) ? IDX_EN2 : IDX_EN1;
         m = 8'(1 << ib[j]);
         wr(e, m);
         @(posedge clk_i);
         ints[j] <= 1'b1;
         @(posedge clk_i);
         if (j > 1) ints[j] <= 1'b0;
         settle(2);
         chk(req_n, 1'b0);
         chk(irq, 1'b0);
         rd(8'(e + 2), m);
         settle(2);
         chk(req_n, 1'(j > 1));
         @(posedge clk_i);
         ints[j] <= 1'b0;
         settle(3);
         chk(req_n, 1'b1);
         wr(e, 8'h00);
      end
      wr(IDX_IEN, 8'h01);
      settle(1);
      chk(irq, 1'b1);
      wr(IDX_ICLR, 8'h01);
      settle(1);
      chk(irq, 1'b0);
      // button off allowed, then refused
      wr(IDX_EN2, RST_EN2);
      drop(P_BUTTON);
      chk(offs, 1);
      chk(sys_on, 1'b0);
      wr(IDX_EN2, 8'h00);
      drop(P_BUTTON);
      chk(offs, 1);
      // a second battery reset in mid-run must restore the enables
      wr(IDX_EN1, 8'hFF);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(IDX_EN1, RST_EN1);
      rd(IDX_EN2, RST_EN2);
      report_and_stop;
   end
endmodule
